// ==== ettc_mem_model.sv ====
// Behavioural main bus memory: 256 longwords, aliased over the address space.
// Assumes the engine holds its request until ack; ack latency comes from lat.
`timescale 1ns/100ps
module ettc_mem_model (
    // Clock, reset and ack latency
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] lat,
    // Main bus
    input wire logic mbus_req,
    input wire logic mbus_we,
    input wire logic [1:0] mbus_size,
    input wire logic [31:0] mbus_addr,
    input wire logic [31:0] mbus_wdata,
    output logic mbus_ack,
    output logic [31:0] mbus_rdata
);
    logic [31:0] mem [0:255];
    logic [3:0] cnt;
    logic [31:0] w;
    logic [4:0] sh;
    assign sh = {mbus_addr[1:0], 3'h0};
    // Read data outside an ack toggles, so a stale word is never mistaken for data.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mbus_ack <= 1'b0;
            cnt <= 4'h0;
            mbus_rdata <= 32'h0;
        end else if (mbus_ack || !mbus_req || cnt < lat) begin
            mbus_ack <= 1'b0;
            cnt <= (mbus_req && !mbus_ack) ? cnt + 4'h1 : 4'h0;
            mbus_rdata <= ~mbus_rdata;
        end else begin
            mbus_ack <= 1'b1;
            w = mem[mbus_addr[9:2]];
            mbus_rdata <= w >> sh;
            if (mbus_we) begin
                if (mbus_size == 2'h0) w[sh+:8] = mbus_wdata[7:0];
                else if (mbus_size == 2'h1) w[sh+:16] = mbus_wdata[15:0];
                else w = mbus_wdata;
                mem[mbus_addr[9:2]] = w;
            end
        end
    end
endmodule

// ==== ettc_pkg.sv ====
// Shared constants for the event triggered transfer engine.
// Assumes a 32-bit APB register bus and a 32-bit on-chip main bus.
package ettc_pkg;

    // Register byte offsets on the APB.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_VBASE = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;

    // Control register fields.
    localparam int CTRL_STOP_BIT = 0;
    localparam int CTRL_SHORT_BIT = 1;
    localparam int CTRL_RSKIP_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;

    // Status register fields.
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CH_LSB = 8;
    localparam int STAT_PEND_LSB = 16;

    // Descriptor layout: four words, sixteen bytes per channel.
    localparam logic [31:0] DESC_BYTES = 32'h10;
    localparam logic [1:0] W_MODE = 2'h0;
    localparam logic [1:0] W_SAR = 2'h1;
    localparam logic [1:0] W_DAR = 2'h2;
    localparam logic [1:0] W_CNT = 2'h3;

    // Mode word fields.
    localparam int MD_MODE_LSB = 0;
    localparam int MD_SIZE_LSB = 2;
    localparam int MD_SMODE_LSB = 4;
    localparam int MD_DMODE_LSB = 6;
    localparam int MD_CHAIN_BIT = 8;
    localparam int MD_CHZERO_BIT = 9;
    localparam int MD_IRQ_UNIT_BIT = 10;
    localparam int MD_RPT_SRC_BIT = 11;
    localparam int MD_FWD_BIT = 12;
    localparam int MD_IRQ_DONE_BIT = 13;

    // Count word fields.
    localparam int CNT_TC_LSB = 0;
    localparam int CNT_CUR_LSB = 16;
    localparam int CNT_RLD_LSB = 24;

    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_REPEAT = 2'h1;
    localparam logic [1:0] MODE_BLOCK = 2'h2;

    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    localparam logic [1:0] AM_FIXED = 2'h0;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [1:0] AM_DEC = 2'h2;

    localparam logic [8:0] RLD_FULL = 9'h100;
    localparam int SHORT_SIGN_BIT = 23;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_RDATA,
        ST_WDATA,
        ST_WBACK,
        ST_NEXT
    } state_e;

endpackage

// ==== event_transfer_controller.sv ====
// Event triggered transfer engine: one channel per trigger source, descriptors in memory.
// Assumes triggers and the main bus run on pclk; the main bus holds ack for one cycle.
//
// How it works
// - normal mode moves one unit per request
// - repeat mode reloads address after repeat size
// - repeat size at most 256 units
// - block mode moves whole block per request
// - unit is byte, word or longword
// - block size field gives 1 to 256
// - chaining runs further descriptors per request
// - chain on zero count or every time
// - short addresses sign extend to 16 MB
// - full addresses cover whole 4 GB
// - optionally forward request source to CPU
// - optional CPU interrupt after each unit
// - optional CPU interrupt when count done
// - event link after each unit or block
// - skip descriptor read on repeated transfer
// - skip write-back of fixed addresses
// - module stop keeps engine inactive
// - data on main bus, registers on APB
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps

module event_transfer_controller
    import ettc_pkg::*;
#(
    parameter int NCH = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger requests from the interrupt controller
    input wire logic [NCH-1:0] trig_req,
    // Main bus master
    output logic mbus_req,
    output logic mbus_we,
    output logic [1:0] mbus_size,
    output logic [31:0] mbus_addr,
    output logic [31:0] mbus_wdata,
    input wire logic mbus_ack,
    input wire logic [31:0] mbus_rdata,
    // Event outputs
    output logic cpu_irq,
    output logic [7:0] cpu_irq_ch,
    output logic event_link,
    output logic busy
);

    localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

    state_e st_q;
    logic [2:0] ctrl_q;
    logic [31:0] vbase_q;
    logic [NCH-1:0] pend_q;
    logic [CW-1:0] ch_q;
    logic [CW-1:0] last_ch_q;
    logic desc_ok_q;
    logic chained_q;
    logic zero_q;
    logic [1:0] wi_q;
    logic [31:0] mode_q;
    logic [31:0] sar_q;
    logic [31:0] dar_q;
    logic [31:0] cnt_q;
    logic [31:0] daddr_q;
    logic [31:0] dbuf_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic mreq_q;
    logic mwe_q;
    logic [1:0] msize_q;
    logic [31:0] maddr_q;
    logic [31:0] mwdata_q;
    logic irq_q;
    logic [7:0] irq_ch_q;
    logic elc_q;
    logic busy_q;

    // Lowest numbered pending channel wins.
    function automatic logic [CW-1:0] pick_lowest(input logic [NCH-1:0] v);
        logic [CW-1:0] r;
        r = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = CW'(i);
            end
        end
        return r;
    endfunction

    // Short mode folds the upper half of a 24-bit space to the top of memory.
    function automatic logic [31:0] eff_addr(input logic [31:0] a, input logic short_m);
        return short_m ? {{8{a[SHORT_SIGN_BIT]}}, a[23:0]} : a;
    endfunction

    // APB decode.
    wire apb_acc = psel & penable;
    wire apb_fire = apb_acc & pready_q;
    wire hit_ctrl = paddr[7:0] == REG_CTRL;
    wire hit_vbase = paddr[7:0] == REG_VBASE;
    wire hit_stat = paddr[7:0] == REG_STATUS;
    wire hit_any = (paddr[31:8] == 24'h000000) & (hit_ctrl | hit_vbase | hit_stat);
    wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire wr_ctrl = apb_fire & pwrite & hit_any & hit_ctrl;
    wire wr_vbase = apb_fire & pwrite & hit_any & hit_vbase;
    wire [31:0] ctrl_wide = {29'h0, ctrl_q};
    wire [31:0] ctrl_new = (ctrl_wide & ~wmask) | (pwdata & wmask);
    wire [31:0] vbase_new = (vbase_q & ~wmask) | (pwdata & wmask);
    wire [31:0] stat_val;
    assign stat_val = ({{(32 - NCH){1'b0}}, pend_q} << STAT_PEND_LSB)
        | ({{(32 - CW){1'b0}}, ch_q} << STAT_CH_LSB)
        | ({31'h0, st_q != ST_IDLE} << STAT_BUSY_BIT);
    wire [31:0] rd_val = hit_ctrl ? ctrl_wide : hit_vbase ? vbase_q : stat_val;

    wire stop_m = ctrl_q[CTRL_STOP_BIT];
    wire short_m = ctrl_q[CTRL_SHORT_BIT];
    wire rskip_m = ctrl_q[CTRL_RSKIP_BIT];

    // Descriptor fields.
    wire [1:0] md_mode = mode_q[MD_MODE_LSB +: 2];
    wire [1:0] md_size = mode_q[MD_SIZE_LSB +: 2];
    wire [1:0] md_smode = mode_q[MD_SMODE_LSB +: 2];
    wire [1:0] md_dmode = mode_q[MD_DMODE_LSB +: 2];
    wire [15:0] tc = cnt_q[CNT_TC_LSB +: 16];
    wire [7:0] cur = cnt_q[CNT_CUR_LSB +: 8];
    wire [7:0] rld = cnt_q[CNT_RLD_LSB +: 8];

    // Unit stride and the way back to the start of a repeat or block area.
    wire [31:0] stride = (md_size == SZ_LONG) ? 32'h4 : (md_size == SZ_WORD) ? 32'h2 : 32'h1;
    wire [1:0] sh = (md_size == SZ_LONG) ? 2'h2 : (md_size == SZ_WORD) ? 2'h1 : 2'h0;
    wire [8:0] rld_n = (rld == 8'h00) ? RLD_FULL : {1'b0, rld};
    wire [31:0] back = {23'h0, rld_n - 9'h1} << sh;
    wire [31:0] sar_step = (md_smode == AM_INC) ? sar_q + stride
        : (md_smode == AM_DEC) ? sar_q - stride : sar_q;
    wire [31:0] dar_step = (md_dmode == AM_INC) ? dar_q + stride
        : (md_dmode == AM_DEC) ? dar_q - stride : dar_q;
    wire [31:0] sar_home = (md_smode == AM_INC) ? sar_q - back
        : (md_smode == AM_DEC) ? sar_q + back : sar_q;
    wire [31:0] dar_home = (md_dmode == AM_INC) ? dar_q - back
        : (md_dmode == AM_DEC) ? dar_q + back : dar_q;

    // Effect of one finished unit on the descriptor.
    wire is_rpt = md_mode == MODE_REPEAT;
    wire is_blk = md_mode == MODE_BLOCK;
    wire wrap = (is_rpt | is_blk) & (cur == 8'h01);
    wire rpt_src = mode_q[MD_RPT_SRC_BIT];
    // Normal mode leaves the repeat and block counter untouched.
    wire [7:0] cur_nxt = wrap ? rld : (is_rpt | is_blk) ? cur - 8'h01 : cur;
    wire [15:0] tc_nxt = (is_rpt | (is_blk & ~wrap)) ? tc : tc - 16'h0001;
    wire [31:0] sar_nxt = (wrap & rpt_src) ? sar_home : sar_step;
    wire [31:0] dar_nxt = (wrap & ~rpt_src) ? dar_home : dar_step;
    wire blk_end = ~is_blk | wrap;
    wire zero_nxt = is_rpt ? wrap : (blk_end & (tc_nxt == 16'h0000));
    wire [31:0] cnt_nxt = {rld, cur_nxt, tc_nxt};

    // Fixed addresses are not written back.
    wire wb_skip = ((wi_q == W_SAR) & (md_smode == AM_FIXED))
        | ((wi_q == W_DAR) & (md_dmode == AM_FIXED));
    wire [31:0] wb_data = (wi_q == W_SAR) ? sar_q : (wi_q == W_DAR) ? dar_q : cnt_q;
    wire [31:0] word_addr = daddr_q + {28'h0, wi_q, 2'h0};

    wire [CW-1:0] pick = pick_lowest(pend_q);
    wire start = (st_q == ST_IDLE) & ~stop_m & (|pend_q);
    wire skip_rd = rskip_m & desc_ok_q & (pick == last_ch_q);
    wire [31:0] slot_addr = vbase_q + ({{(32 - CW){1'b0}}, pick} << 4);
    wire chain_go = mode_q[MD_CHAIN_BIT] & (~mode_q[MD_CHZERO_BIT] | zero_q);
    wire unit_done = (st_q == ST_WDATA) & mreq_q & mbus_ack;
    wire end_irq = (st_q == ST_NEXT)
        & (mode_q[MD_FWD_BIT] | (mode_q[MD_IRQ_DONE_BIT] & zero_q));

    // Pending request per channel; a new request beats the clear of a start.
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_pend
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pend_q[g] <= 1'b0;
                end else begin
                    pend_q[g] <= trig_req[g] | (pend_q[g] & ~(start & (pick == CW'(g))));
                end
            end
        end
    endgenerate

    // APB register file.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
            vbase_q <= 32'h0;
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= apb_acc & ~pready_q;
            // The error flag stands only in the cycle in which pready does.
            pslverr_q <= apb_acc & ~pready_q & ~hit_any;
            if (apb_acc & ~pready_q) begin
                prdata_q <= (hit_any & ~pwrite) ? rd_val : 32'h0;
            end
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new[2:0];
            end
            if (wr_vbase) begin
                vbase_q <= vbase_new;
            end
        end
    end

    // Transfer sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            ch_q <= '0;
            last_ch_q <= '0;
            desc_ok_q <= 1'b0;
            chained_q <= 1'b0;
            zero_q <= 1'b0;
            wi_q <= 2'h0;
            mode_q <= 32'h0;
            sar_q <= 32'h0;
            dar_q <= 32'h0;
            cnt_q <= 32'h0;
            daddr_q <= 32'h0;
            dbuf_q <= 32'h0;
            mreq_q <= 1'b0;
            mwe_q <= 1'b0;
            msize_q <= SZ_BYTE;
            maddr_q <= 32'h0;
            mwdata_q <= 32'h0;
            busy_q <= 1'b0;
        end else begin
            if (wr_vbase) begin
                desc_ok_q <= 1'b0;
            end
            unique case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        ch_q <= pick;
                        busy_q <= 1'b1;
                        chained_q <= 1'b0;
                        daddr_q <= slot_addr;
                        wi_q <= W_MODE;
                        st_q <= skip_rd ? ST_RDATA : ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (!mreq_q) begin
                        mreq_q <= 1'b1;
                        mwe_q <= 1'b0;
                        msize_q <= SZ_LONG;
                        maddr_q <= word_addr;
                    end else if (mbus_ack) begin
                        mreq_q <= 1'b0;
                        unique case (wi_q)
                            W_MODE: mode_q <= mbus_rdata;
                            W_SAR: sar_q <= mbus_rdata;
                            W_DAR: dar_q <= mbus_rdata;
                            W_CNT: cnt_q <= mbus_rdata;
                        endcase
                        wi_q <= wi_q + 2'h1;
                        if (wi_q == W_CNT) begin
                            st_q <= ST_RDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (!mreq_q) begin
                        mreq_q <= 1'b1;
                        mwe_q <= 1'b0;
                        msize_q <= md_size;
                        maddr_q <= eff_addr(sar_q, short_m);
                    end else if (mbus_ack) begin
                        mreq_q <= 1'b0;
                        dbuf_q <= mbus_rdata;
                        st_q <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (!mreq_q) begin
                        mreq_q <= 1'b1;
                        mwe_q <= 1'b1;
                        msize_q <= md_size;
                        maddr_q <= eff_addr(dar_q, short_m);
                        mwdata_q <= dbuf_q;
                    end else if (mbus_ack) begin
                        mreq_q <= 1'b0;
                        sar_q <= sar_nxt;
                        dar_q <= dar_nxt;
                        cnt_q <= cnt_nxt;
                        zero_q <= zero_nxt;
                        wi_q <= W_SAR;
                        st_q <= blk_end ? ST_WBACK : ST_RDATA;
                    end
                end
                ST_WBACK: begin
                    if (wb_skip) begin
                        wi_q <= wi_q + 2'h1;
                    end else if (!mreq_q) begin
                        mreq_q <= 1'b1;
                        mwe_q <= 1'b1;
                        msize_q <= SZ_LONG;
                        maddr_q <= word_addr;
                        mwdata_q <= wb_data;
                    end else if (mbus_ack) begin
                        mreq_q <= 1'b0;
                        wi_q <= wi_q + 2'h1;
                    end
                    if ((wb_skip | (mreq_q & mbus_ack)) & (wi_q == W_CNT)) begin
                        st_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    wi_q <= W_MODE;
                    if (chain_go) begin
                        daddr_q <= daddr_q + DESC_BYTES;
                        chained_q <= 1'b1;
                        desc_ok_q <= 1'b0;
                        st_q <= ST_FETCH;
                    end else begin
                        // A base rewrite in this very cycle invalidates the held descriptor.
                        desc_ok_q <= ~chained_q & ~wr_vbase;
                        last_ch_q <= ch_q;
                        busy_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // CPU interrupt and event link pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            irq_ch_q <= 8'h00;
            elc_q <= 1'b0;
        end else begin
            irq_q <= (unit_done & mode_q[MD_IRQ_UNIT_BIT]) | end_irq;
            irq_ch_q <= 8'(ch_q);
            elc_q <= unit_done & blk_end;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mbus_req = mreq_q;
    assign mbus_we = mwe_q;
    assign mbus_size = msize_q;
    assign mbus_addr = maddr_q;
    assign mbus_wdata = mwdata_q;
    assign cpu_irq = irq_q;
    assign cpu_irq_ch = irq_ch_q;
    assign event_link = elc_q;
    // Busy is a flop that follows the sequencer leaving and reaching idle.
    assign busy = busy_q;

endmodule

// ==== event_transfer_controller_bench.sv ====
// Self-checking bench: APB register access and triggered transfers.
// Assumes the memory model holds descriptors at 0x100 and data from 0x200.
`timescale 1ns/100ps
module event_transfer_controller_bench import ettc_pkg::*; ;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, mbus_req, mbus_we, mbus_ack, cpu_irq, event_link, busy;
    logic [31:0] paddr = 0, pwdata = 0, prdata, mbus_addr, mbus_wdata, mbus_rdata;
    logic [3:0] pstrb = 4'hf, lat = 0;
    logic [7:0] trig_req = 0, cpu_irq_ch, last_ch = 0;
    logic [1:0] mbus_size;
    int n_fail = 0, check_count = 0, n_link = 0, n_irq = 0, wb_dar = 0, saw_ff = 0;
    event_transfer_controller #(.NCH(8)) event_transfer_controller_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .trig_req,
        .mbus_req, .mbus_we, .mbus_size, .mbus_addr, .mbus_wdata, .mbus_ack, .mbus_rdata,
        .cpu_irq, .cpu_irq_ch, .event_link, .busy);
    ettc_mem_model ettc_mem_model_i (.pclk, .presetn, .lat, .mbus_req, .mbus_we, .mbus_size,
        .mbus_addr, .mbus_wdata, .mbus_ack, .mbus_rdata);
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        if (event_link === 1'b1) n_link++;
        if (cpu_irq === 1'b1) begin
            n_irq++;
            last_ch = cpu_irq_ch;
        end
        if (mbus_req && mbus_ack && mbus_we && mbus_addr === 32'h118) wb_dar++;
        if (mbus_req && mbus_ack && mbus_addr === 32'hff800230) saw_ff = 1;
    end
    task automatic wrap_up;
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d, ex, input logic xe);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        if (!w) chk(prdata, ex);
        chk({31'h0, pslverr}, {31'h0, xe});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Waits until the engine has stayed idle for four edges, so queued channels are served too.
    task automatic run;
        int idle;
        idle = 0;
        repeat (4) @(posedge pclk);
        while (idle < 4) begin
            @(posedge pclk);
            idle = (busy === 1'b0) ? idle + 1 : 0;
        end
    endtask
    task automatic trig(input logic [7:0] m);
        trig_req <= m;
        @(posedge pclk);
        trig_req <= 8'h0;
        run();
    endtask
    task automatic desc(input int ch, input logic [31:0] a, b, c, d);
        ettc_mem_model_i.mem[64 + 4 * ch] = a;
        ettc_mem_model_i.mem[65 + 4 * ch] = b;
        ettc_mem_model_i.mem[66 + 4 * ch] = c;
        ettc_mem_model_i.mem[67 + 4 * ch] = d;
    endtask
    function automatic logic [31:0] mw(logic [1:0] mo, sz, sm, dm, logic [31:0] x);
        return x | {24'h0, dm, sm, sz, mo};
    endfunction
    function automatic logic [31:0] m(int i);
        return ettc_mem_model_i.mem[i];
    endfunction
    initial begin
        for (int i = 0; i < 256; i++) ettc_mem_model_i.mem[i] = (i == 248) ? '1 : 32'h0;
        for (int i = 0; i < 16; i++) ettc_mem_model_i.mem[128 + i] = {8'(i), 8'h5a, 8'(i), 8'hc3};
        desc(0, mw(MODE_NORMAL, SZ_LONG, AM_INC, AM_INC, 0), 32'h200, 32'h280, 32'h2);
        desc(1, mw(MODE_REPEAT, SZ_LONG, AM_INC, AM_FIXED, 32'h1 << MD_RPT_SRC_BIT
            | 32'h1 << MD_IRQ_UNIT_BIT), 32'h210, 32'h300, 32'h0202_0010);
        desc(2, mw(MODE_BLOCK, SZ_LONG, AM_INC, AM_INC, 32'h1 << MD_IRQ_DONE_BIT), 32'h220,
            32'h380, 32'h0303_0001);
        desc(3, mw(MODE_NORMAL, SZ_LONG, AM_INC, AM_FIXED, 32'h1 << MD_CHAIN_BIT
            | 32'h1 << MD_CHZERO_BIT), 32'h204, 32'h3f0, 32'h1);
        desc(4, mw(MODE_NORMAL, SZ_BYTE, AM_INC, AM_FIXED, 0), 32'h208, 32'h3e0, 32'h1);
        desc(5, mw(MODE_NORMAL, SZ_LONG, AM_INC, AM_FIXED, 0), 32'h0080_0230, 32'h3d0, 32'h1);
        desc(6, mw(MODE_NORMAL, SZ_WORD, AM_DEC, AM_FIXED, 32'h1 << MD_FWD_BIT), 32'h20c,
            32'h3f0, 32'h1);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 32'(REG_CTRL), 0, 32'(CTRL_RESET), 0);
        apb(0, 32'(REG_STATUS), 0, 0, 0);
        apb(0, 32'h0c, 0, 0, 1);
        apb(1, 32'h100, 32'h5, 0, 1);
        apb(1, 32'(REG_VBASE), 32'h100, 0, 0);
        apb(0, 32'(REG_VBASE), 0, 32'h100, 0);
        trig(8'h01);
        chk({31'h0, busy}, 0);
        apb(0, 32'(REG_STATUS), 0, 32'h1 << STAT_PEND_LSB, 0);
        apb(1, 32'(REG_CTRL), 32'h0, 0, 0);
        run();
        chk(m(160), 32'h005a00c3);
        chk(m(161), 0);
        chk(m(65), 32'h204);
        chk(m(67), 32'h1);
        chk(n_link, 1);
        apb(1, 32'(REG_STATUS), '1, 0, 0);
        apb(0, 32'(REG_STATUS), 0, 0, 0);
        repeat (3) trig(8'h02);
        chk(m(192), 32'h045a04c3);
        chk(m(69), 32'h214);
        chk({24'h0, ettc_mem_model_i.mem[71][23:16]}, 32'h1);
        chk(n_irq, 3);
        chk({24'h0, last_ch}, 32'h1);
        chk(wb_dar, 0);
        lat <= 4'h3;
        trig(8'h04);
        chk(m(224), 32'h085a08c3);
        chk(m(226), 32'h0a5a0ac3);
        chk(m(227), 0);
        chk(m(74), 32'h380);
        chk(n_link, 5);
        chk(n_irq, 4);
        lat <= 4'h1;
        trig(8'h48);
        chk(m(252), 32'h015a03c3);
        chk(m(248), 32'hffffffc3);
        chk({24'h0, last_ch}, 32'h6);
        chk(m(89), 32'h20a);
        apb(1, 32'(REG_CTRL), 32'h2, 0, 0);
        trig(8'h20);
        chk(saw_ff, 1);
        chk(m(244), 32'h0c5a0cc3);
        apb(1, 32'(REG_CTRL), 32'h4, 0, 0);
        // A skipped read must ignore this altered source word in memory.
        ettc_mem_model_i.mem[85] = 32'h200;
        trig(8'h20);
        chk(m(244), 32'h0d5a0dc3);
        chk(m(85), 32'h00800238);
        wrap_up();
    end
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
endmodule

// ==== event_transfer_controller_properties.sv ====
// Port checker for the transfer engine.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/100ps
module event_transfer_controller_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Main bus
    input wire logic mbus_req,
    input wire logic mbus_we,
    input wire logic [1:0] mbus_size,
    input wire logic [31:0] mbus_addr,
    input wire logic [31:0] mbus_wdata,
    input wire logic mbus_ack,
    // Events
    input wire logic cpu_irq,
    input wire logic event_link,
    input wire logic busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb wait wrong");
    a_err_unmapped: assert property (psel && penable && !pready && paddr[31:8] != 24'h0
        |=> pready && pslverr) else $error("unmapped access not refused");
    a_err_with_ready: assert property (pslverr |-> pready && psel)
        else $error("stray error");
    a_req_held: assert property (mbus_req && !mbus_ack |=> mbus_req && $stable(mbus_addr)
        && $stable(mbus_size) && $stable(mbus_we) && (!mbus_we || $stable(mbus_wdata)))
        else $error("request not held");
    a_req_gap: assert property (mbus_req && mbus_ack |=> !mbus_req)
        else $error("no idle after ack");
    a_unit_width: assert property (mbus_req |-> mbus_size != 2'h3)
        else $error("bad unit size");
    a_link_after_wr: assert property ($rose(event_link) |-> $past(mbus_ack && mbus_we))
        else $error("link without write");
    a_link_pulse: assert property (event_link |=> !event_link)
        else $error("link too long");
    a_irq_pulse: assert property (cpu_irq |=> !cpu_irq)
        else $error("irq too long");
    a_idle_no_req: assert property (!busy |-> !mbus_req)
        else $error("request while idle");
    c_link: cover property (event_link);
    c_irq: cover property (cpu_irq);
    c_err: cover property (pslverr);
    c_slow: cover property (mbus_req && !mbus_ack ##1 mbus_req && !mbus_ack);
endmodule
bind event_transfer_controller event_transfer_controller_properties props_i (.pclk, .presetn,
    .psel, .penable, .paddr, .pready, .pslverr, .mbus_req, .mbus_we, .mbus_size, .mbus_addr,
    .mbus_wdata, .mbus_ack, .cpu_irq, .event_link, .busy);
